// *** rtl/vchmc_top.sv ***
// valve channel manual control: modes, supply error, defaults, manual coil drive, input filters
// assumes one 200 MHz clock, a plain register port and synchronous inputs
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "vchmc_regs.svh"
module vchmc_top
   import vchmc_pkg::*;
#(
   parameter int N_AIN = 2,
   parameter int AW = 16
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // system status
   input wire logic link_online,
   input wire logic supply_low,
   // analog samples
   input wire logic [N_AIN-1:0] ain_vld,
   input wire logic [N_AIN*AW-1:0] ain_data,
   // non-volatile storage interface
   output logic nv_store,
   output logic [15:0] nv_imin,
   output logic [15:0] nv_imax,
   output logic [N_AIN*`VCHMC_FILT_FIELD-1:0] nv_filt,
   input wire logic [15:0] nv_imin_in,
   input wire logic [15:0] nv_imax_in,
   input wire logic [N_AIN*`VCHMC_FILT_FIELD-1:0] nv_filt_in,
   input wire logic nv_valid,
   // outputs
   output logic [15:0] coil_current,
   output logic irq
);
   // ==========================================================
   // reset release
   logic rst_s1_reg;
   logic rst_n;
   // two-stage release of the async reset
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_s1_reg <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_n <= rst_s1_reg;
      end
   end
   // ==========================================================
   // register state
   logic remote_host_mode_reg;
   logic active_reg;
   logic run_reg;
   logic autoack_reg;
   logic switching_reg;
   logic [9:0] setpt_reg;
   logic [15:0] imin_reg;
   logic [15:0] imax_reg;
   logic [15:0] imin_saved_reg;
   logic [15:0] imax_saved_reg;
   logic [N_AIN*`VCHMC_FILT_FIELD-1:0] filt_reg;
   logic superr_reg;
   logic [`VCHMC_IRQ_W-1:0] irq_stat_reg;
   logic [`VCHMC_IRQ_W-1:0] irq_mask_reg;
   logic nv_loaded_reg;
   logic wr_ctrl;
   logic wr_cmd;
   logic rd_irq;
   logic def_ok;
   logic def_req;
   logic commit_req;
   logic ctrl_refused;
   logic [`VCHMC_IRQ_W-1:0] irq_ev;

   assign wr_ctrl = reg_wr && (reg_addr == `VCHMC_OFS_CTRL);
   assign wr_cmd = reg_wr && (reg_addr == `VCHMC_OFS_CMD);
   assign rd_irq = reg_rd && (reg_addr == `VCHMC_OFS_IRQ_STAT);
   assign def_ok = link_online && !active_reg;
   assign def_req = wr_cmd && reg_wdata[`VCHMC_CMD_DEFLOAD];
   assign commit_req = wr_cmd && reg_wdata[`VCHMC_CMD_COMMIT];
   // mode and state requests: each one checked against the current other
   logic mode_req;
   logic state_req;
   assign mode_req = wr_ctrl && (reg_wdata[`VCHMC_CTRL_REMOTE] != remote_host_mode_reg);
   assign state_req = wr_ctrl && (reg_wdata[`VCHMC_CTRL_ACTIVE] != active_reg);
   assign ctrl_refused = (mode_req && active_reg) || (state_req && !remote_host_mode_reg)
      || (def_req && !def_ok);
   // operating mode: local or remote
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         remote_host_mode_reg <= 1'b0;
      else if (mode_req && !active_reg)
         remote_host_mode_reg <= reg_wdata[`VCHMC_CTRL_REMOTE];
   end
   // control state: disabled or active
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         active_reg <= 1'b0;
      else if (state_req && remote_host_mode_reg)
         active_reg <= reg_wdata[`VCHMC_CTRL_ACTIVE];
   end
   // manual start/stop, dropped when leaving active
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         run_reg <= 1'b0;
      else if (!active_reg || !remote_host_mode_reg)
         run_reg <= 1'b0;
      else if (wr_ctrl)
         run_reg <= reg_wdata[`VCHMC_CTRL_RUN];
   end
   // plain options
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         autoack_reg <= 1'b0;
         switching_reg <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         autoack_reg <= reg_wdata[`VCHMC_CTRL_AUTOACK];
         switching_reg <= reg_wdata[`VCHMC_CTRL_SWITCH];
      end
   end
   // setpoint, clamped at full scale
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         setpt_reg <= '0;
      else if (reg_wr && reg_addr == `VCHMC_OFS_SETPT)
         setpt_reg <= (reg_wdata[9:0] > `VCHMC_SETPT_FULL) ? `VCHMC_SETPT_FULL : reg_wdata[9:0];
   end
   // ==========================================================
   // current range edit with confirm/cancel, defaults and power-up restore
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         imin_reg <= `VCHMC_DEF_IMIN;
         imax_reg <= `VCHMC_DEF_IMAX;
         imin_saved_reg <= `VCHMC_DEF_IMIN;
         imax_saved_reg <= `VCHMC_DEF_IMAX;
         filt_reg <= '0;
         nv_loaded_reg <= 1'b0;
      end
      else if (!nv_loaded_reg && nv_valid)
      begin
         // stored values come back after power-up
         imin_reg <= nv_imin_in;
         imax_reg <= nv_imax_in;
         imin_saved_reg <= nv_imin_in;
         imax_saved_reg <= nv_imax_in;
         filt_reg <= nv_filt_in;
         nv_loaded_reg <= 1'b1;
      end
      else if (def_req && def_ok)
      begin
         imin_reg <= `VCHMC_DEF_IMIN;
         imax_reg <= `VCHMC_DEF_IMAX;
         imin_saved_reg <= `VCHMC_DEF_IMIN;
         imax_saved_reg <= `VCHMC_DEF_IMAX;
         filt_reg <= '0;
      end
      else if (wr_cmd && reg_wdata[`VCHMC_CMD_CONFIRM])
      begin
         imin_saved_reg <= imin_reg;
         imax_saved_reg <= imax_reg;
      end
      else if (wr_cmd && reg_wdata[`VCHMC_CMD_CANCEL])
      begin
         imin_reg <= imin_saved_reg;
         imax_reg <= imax_saved_reg;
      end
      else if (reg_wr && reg_addr == `VCHMC_OFS_IMIN)
         imin_reg <= reg_wdata[15:0];
      else if (reg_wr && reg_addr == `VCHMC_OFS_IMAX)
         imax_reg <= reg_wdata[15:0];
      else if (reg_wr && reg_addr == `VCHMC_OFS_FILT)
         filt_reg <= reg_wdata[N_AIN*`VCHMC_FILT_FIELD-1:0];
   end
   // non-volatile write only on explicit commit
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         nv_store <= 1'b0;
         nv_imin <= '0;
         nv_imax <= '0;
         nv_filt <= '0;
      end
      else
      begin
         nv_store <= commit_req;
         if (commit_req)
         begin
            nv_imin <= imin_reg;
            nv_imax <= imax_reg;
            nv_filt <= filt_reg;
         end
      end
   end
   // ==========================================================
   // supply error latch
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         superr_reg <= 1'b0;
      else if (supply_low)
         superr_reg <= 1'b1;
      else if (autoack_reg)
         superr_reg <= 1'b0;
      else if (state_req && remote_host_mode_reg && reg_wdata[`VCHMC_CTRL_ACTIVE] && !active_reg)
         superr_reg <= 1'b0;
   end
   // ==========================================================
   // coil current: linear map or switch, zero when stopped
   function automatic logic [15:0] map_pct(input logic [9:0] sp, input logic [15:0] lo,
                                           input logic [15:0] hi);
      logic [15:0] span;
      logic [25:0] prod;
      span = (hi > lo) ? (hi - lo) : 16'h0000;
      prod = 26'(span) * 26'(sp);
      map_pct = lo + 16'(prod / 26'(`VCHMC_SETPT_FULL));
   endfunction

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         coil_current <= '0;
      else if (!run_reg || superr_reg)
         coil_current <= '0;
      else if (switching_reg)
         coil_current <= setpt_reg[0] ? imax_reg : 16'h0000;
      else
         coil_current <= map_pct(setpt_reg, imin_reg, imax_reg);
   end

   // ==========================================================
   // analog input filters
   logic [N_AIN*AW-1:0] ain_filt;

   genvar gi;
   generate
      for (gi = 0; gi < N_AIN; gi++)
      begin : g_ain
         vchmc_ema #(.W(AW)) u_ema (
            .clk(clk),
            .rst_n(rst_n),
            .smooth_en(filt_reg[gi*`VCHMC_FILT_FIELD]),
            .sf(vchmc_sf_t'(filt_reg[gi*`VCHMC_FILT_FIELD+1 +: 2])),
            .sample_vld(ain_vld[gi]),
            .sample(ain_data[gi*AW +: AW]),
            .filt(ain_filt[gi*AW +: AW])
         );
      end
   endgenerate

   // ==========================================================
   // interrupts: sticky, cleared by read, set wins
   assign irq_ev = {ctrl_refused, commit_req, def_req && def_ok, supply_low && !superr_reg};

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_stat_reg <= '0;
      else if (rd_irq)
         irq_stat_reg <= irq_ev;
      else
         irq_stat_reg <= irq_stat_reg | irq_ev;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_mask_reg <= '0;
      else if (reg_wr && reg_addr == `VCHMC_OFS_IRQ_MASK)
         irq_mask_reg <= reg_wdata[`VCHMC_IRQ_W-1:0];
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irq <= 1'b0;
      else
         irq <= |((irq_stat_reg | irq_ev) & irq_mask_reg & ~({`VCHMC_IRQ_W{rd_irq}} & irq_stat_reg & ~irq_ev));
   end

   // ==========================================================
   // read mux
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= '0;
      else if (reg_rd)
      begin
         unique case (reg_addr)
            `VCHMC_OFS_CTRL: reg_rdata <= 32'({switching_reg, autoack_reg, run_reg, active_reg,
                                               remote_host_mode_reg});
            `VCHMC_OFS_STATUS: reg_rdata <= 32'({def_ok, superr_reg});
            `VCHMC_OFS_IRQ_STAT: reg_rdata <= 32'(irq_stat_reg);
            `VCHMC_OFS_IRQ_MASK: reg_rdata <= 32'(irq_mask_reg);
            `VCHMC_OFS_FILT: reg_rdata <= 32'(filt_reg);
            `VCHMC_OFS_SETPT: reg_rdata <= 32'(setpt_reg);
            `VCHMC_OFS_IMIN: reg_rdata <= 32'(imin_reg);
            `VCHMC_OFS_IMAX: reg_rdata <= 32'(imax_reg);
            `VCHMC_OFS_COIL: reg_rdata <= 32'(coil_current);
            `VCHMC_OFS_AIN0: reg_rdata <= 32'(ain_filt[AW-1:0]);
            `VCHMC_OFS_AIN1: reg_rdata <= 32'(ain_filt[(N_AIN-1)*AW +: AW]);
            default: reg_rdata <= '0;
         endcase
      end
      else
         reg_rdata <= '0;
   end

   // ==========================================================
   // checks
   sequence s_start_ok;
      run_reg && !superr_reg && !switching_reg;
   endsequence

   chk_mode_locked: assert property (@(posedge clk) disable iff (!rst_n)
      active_reg |=> $stable(remote_host_mode_reg)) else $error("mode changed while active");
   chk_state_remote: assert property (@(posedge clk) disable iff (!rst_n)
      !remote_host_mode_reg |=> $stable(active_reg)) else $error("state changed while local");
   chk_run_gate: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(run_reg) |-> $past(active_reg) && $past(remote_host_mode_reg)) else $error("run outside remote active");
   chk_stop_zero: assert property (@(posedge clk) disable iff (!rst_n)
      !run_reg |=> coil_current == 16'h0000) else $error("current while stopped");
   chk_prop_floor: assert property (@(posedge clk) disable iff (!rst_n)
      s_start_ok ##1 $stable(imin_reg) |-> coil_current >= imin_reg) else $error("current under imin");
   chk_autoack_clr: assert property (@(posedge clk) disable iff (!rst_n)
      superr_reg && autoack_reg && !supply_low |=> !superr_reg) else $error("supply error not auto cleared");
   chk_err_hold: assert property (@(posedge clk) disable iff (!rst_n)
      superr_reg && !autoack_reg && !wr_ctrl |=> superr_reg) else $error("supply error lost");
   chk_def_gate: assert property (@(posedge clk) disable iff (!rst_n)
      def_req && !def_ok |=> irq_stat_reg[`VCHMC_ST_REFUSED]) else $error("refused load not flagged");
endmodule
`default_nettype wire

// *** include/vchmc_regs.svh ***
// register map, field positions and reset values for the valve channel
// assumes a 32-bit plain register port with word-aligned byte addresses
`ifndef VCHMC_REGS_SVH
`define VCHMC_REGS_SVH
// ==========================================================
// register byte addresses
`define VCHMC_OFS_CTRL     8'h00
`define VCHMC_OFS_STATUS   8'h04
`define VCHMC_OFS_IRQ_STAT 8'h08
`define VCHMC_OFS_IRQ_MASK 8'h0c
`define VCHMC_OFS_FILT     8'h10
`define VCHMC_OFS_SETPT    8'h14
`define VCHMC_OFS_IMIN     8'h18
`define VCHMC_OFS_IMAX     8'h1c
`define VCHMC_OFS_CMD      8'h20
`define VCHMC_OFS_COIL     8'h24
`define VCHMC_OFS_AIN0     8'h28
`define VCHMC_OFS_AIN1     8'h2c
// ==========================================================
// control register fields
`define VCHMC_CTRL_REMOTE  0
`define VCHMC_CTRL_ACTIVE  1
`define VCHMC_CTRL_RUN     2
`define VCHMC_CTRL_AUTOACK 3
`define VCHMC_CTRL_SWITCH  4
// command register fields, write-one pulses
`define VCHMC_CMD_DEFLOAD  0
`define VCHMC_CMD_COMMIT   1
`define VCHMC_CMD_CONFIRM  2
`define VCHMC_CMD_CANCEL   3
// status / interrupt fields
`define VCHMC_ST_SUPERR    0
`define VCHMC_ST_DEFDONE   1
`define VCHMC_ST_COMMITREQ 2
`define VCHMC_ST_REFUSED   3
`define VCHMC_IRQ_W        4
// filter config: per input, bit0 type, bits2:1 factor code
`define VCHMC_FILT_FIELD   4
// ==========================================================
// setpoint full scale, reset and factory values
`define VCHMC_SETPT_FULL   10'h3e8
`define VCHMC_DEF_IMIN     16'h0064
`define VCHMC_DEF_IMAX     16'h0320
`define VCHMC_DEF_FILT     8'h00
`endif

// *** include/vchmc_pkg.sv ***
// types for the valve channel manual control block
// assumes nothing beyond a SystemVerilog compiler
package vchmc_pkg;
   // ==========================================================
   // smoothing factor codes
   typedef enum logic [1:0] {
      VCHMC_SF8  = 2'b00,
      VCHMC_SF16 = 2'b01,
      VCHMC_SF32 = 2'b10,
      VCHMC_SF64 = 2'b11
   } vchmc_sf_t;
endpackage

// *** rtl/vchmc_ema.sv ***
// one analog input smoothing filter with bypass
// assumes sample_vld pulses one cycle per new sample
`timescale 1ns/1ps
`default_nettype none
module vchmc_ema
   import vchmc_pkg::*;
#(
   parameter int W = 16
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // configuration
   input wire logic smooth_en,
   input wire vchmc_sf_t sf,
   // sample stream
   input wire logic sample_vld,
   input wire logic [W-1:0] sample,
   output logic [W-1:0] filt
);
   // ==========================================================
   // shift amount from factor code
   function automatic logic [2:0] sf_shift(input vchmc_sf_t c);
      sf_shift = 3'h3 + {1'b0, c};
   endfunction

   logic signed [W+1:0] diff;
   logic signed [W+1:0] step;
   logic [W-1:0] filt_next;

   // output plus difference shifted by factor
   always_comb
   begin
      diff = $signed({2'b00, sample}) - $signed({2'b00, filt});
      step = diff >>> sf_shift(sf);
      filt_next = W'($signed({2'b00, filt}) + step);
   end

   // register filter state
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         filt <= '0;
      else if (sample_vld)
      begin
         if (smooth_en)
            filt <= filt_next;
         else
            filt <= sample;
      end
   end
endmodule
`default_nettype wire

// *** sim/vchmc_nv_model.sv ***
// storage model standing in for the non-volatile store of the channel
// assumes rstn low marks a power cycle; stored values survive it
`timescale 1ns/1ps
`default_nettype none
module vchmc_nv_model
#(
   parameter logic [15:0] IMIN0 = 16'h0050,
   parameter logic [15:0] IMAX0 = 16'h0200,
   parameter int FW = 8
)
(
   // clock and power
   input wire logic clk,
   input wire logic rstn,
   // store port
   input wire logic nv_store,
   input wire logic [15:0] nv_imin,
   input wire logic [15:0] nv_imax,
   input wire logic [FW-1:0] nv_filt,
   // restore port
   output logic [15:0] nv_imin_in,
   output logic [15:0] nv_imax_in,
   output logic [FW-1:0] nv_filt_in,
   output logic nv_valid
);
   logic [15:0] imin_reg = IMIN0;
   logic [15:0] imax_reg = IMAX0;
   logic [FW-1:0] filt_reg = '0;
   logic [2:0] cnt_reg;
   // ==========================================================
   // contents change only on a store pulse
   always_ff @(posedge clk)
   begin
      if (nv_store)
      begin
         imin_reg <= nv_imin;
         imax_reg <= nv_imax;
         filt_reg <= nv_filt;
      end
   end
   // stored set offered a few cycles after power-up
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         cnt_reg <= 3'h0;
      else if (cnt_reg != 3'h5)
         cnt_reg <= cnt_reg + 3'h1;
   end
   assign nv_valid = (cnt_reg == 3'h5);
   // data not offered shows inverted values
   assign nv_imin_in = nv_valid ? imin_reg : ~imin_reg;
   assign nv_imax_in = nv_valid ? imax_reg : ~imax_reg;
   assign nv_filt_in = nv_valid ? filt_reg : ~filt_reg;
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for the valve channel manual control block
// assumes the storage model stands on the non-volatile port
`timescale 1ns/1ps
`default_nettype none
`include "vchmc_regs.svh"
module tb_top;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic link_online = 1'b0;
   logic supply_low = 1'b0;
   logic [1:0] ain_vld = 2'b00;
   logic [31:0] ain_data = 32'h0;
   logic nv_store;
   logic nv_valid;
   logic [15:0] nv_imin;
   logic [15:0] nv_imax;
   logic [15:0] nv_imin_in;
   logic [15:0] nv_imax_in;
   logic [7:0] nv_filt;
   logic [7:0] nv_filt_in;
   logic [15:0] coil_current;
   logic irq;
   int num_errors = 0;
   int num_checks = 0;
   // ==========================================================
   // clock, design and storage
   always #2.5 clk = ~clk;
   vchmc_top #(.N_AIN(2), .AW(16)) dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .link_online(link_online), .supply_low(supply_low), .ain_vld(ain_vld), .ain_data(ain_data),
      .nv_store(nv_store), .nv_imin(nv_imin), .nv_imax(nv_imax), .nv_filt(nv_filt),
      .nv_imin_in(nv_imin_in), .nv_imax_in(nv_imax_in), .nv_filt_in(nv_filt_in),
      .nv_valid(nv_valid), .coil_current(coil_current), .irq(irq));
   vchmc_nv_model nv (.clk(clk), .rstn(rstn), .nv_store(nv_store), .nv_imin(nv_imin),
      .nv_imax(nv_imax), .nv_filt(nv_filt), .nv_imin_in(nv_imin_in), .nv_imax_in(nv_imax_in),
      .nv_filt_in(nv_filt_in), .nv_valid(nv_valid));
   // ==========================================================
   // bus and compare helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk(d, e);
   endtask
   task automatic power();
      @(posedge clk);
      rstn <= 1'b0;
      cyc(12);
      rstn <= 1'b1;
      cyc(8);
   endtask
   task automatic supply(input logic v);
      @(posedge clk);
      supply_low <= v;
      cyc(3);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset();
      rc(`VCHMC_OFS_CTRL, 32'h0);
      chk(coil_current, 32'h0);
      rc(`VCHMC_OFS_IMIN, 32'h50);
      rc(8'h40, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_modes();
      wr(`VCHMC_OFS_IRQ_MASK, 32'h8);
      wr(`VCHMC_OFS_CTRL, 32'h2);
      rc(`VCHMC_OFS_CTRL, 32'h0);
      cyc(1);
      chk(irq, 32'h1);
      rc(`VCHMC_OFS_IRQ_STAT, 32'h8);
      cyc(2);
      chk(irq, 32'h0);
      wr(`VCHMC_OFS_CTRL, 32'h1);
      wr(`VCHMC_OFS_CTRL, 32'h3);
      rc(`VCHMC_OFS_CTRL, 32'h3);
      wr(`VCHMC_OFS_CTRL, 32'h2);
      rc(`VCHMC_OFS_CTRL, 32'h3);
      wr(`VCHMC_OFS_CTRL, 32'h1);
      wr(`VCHMC_OFS_CTRL, 32'h0);
      rc(`VCHMC_OFS_CTRL, 32'h0);
      wr(`VCHMC_OFS_IRQ_MASK, 32'h0);
      rc(`VCHMC_OFS_IRQ_STAT, 32'h8);
      $display("mode test done");
   endtask
   task automatic t_limits();
      wr(`VCHMC_OFS_IMIN, 32'd100);
      wr(`VCHMC_OFS_IMAX, 32'd1100);
      wr(`VCHMC_OFS_CMD, 32'h4);
      rc(`VCHMC_OFS_IMIN, 32'd100);
      wr(`VCHMC_OFS_IMIN, 32'd200);
      wr(`VCHMC_OFS_IMAX, 32'd900);
      wr(`VCHMC_OFS_CMD, 32'h8);
      rc(`VCHMC_OFS_IMIN, 32'd100);
      rc(`VCHMC_OFS_IMAX, 32'd1100);
      $display("limits test done");
   endtask
   task automatic t_manual();
      int sp[3] = '{0, 500, 1000};
      wr(`VCHMC_OFS_SETPT, 32'd500);
      wr(`VCHMC_OFS_CTRL, 32'h4);
      rc(`VCHMC_OFS_CTRL, 32'h0);
      wr(`VCHMC_OFS_CTRL, 32'h1);
      wr(`VCHMC_OFS_CTRL, 32'h5);
      rc(`VCHMC_OFS_CTRL, 32'h1);
      chk(coil_current, 32'h0);
      wr(`VCHMC_OFS_CTRL, 32'h3);
      wr(`VCHMC_OFS_CTRL, 32'h7);
      // span of 1000 makes the expected current 100 plus setpoint
      for (int i = 0; i < 3; i++)
      begin
         wr(`VCHMC_OFS_SETPT, 32'(sp[i]));
         cyc(3);
         chk(coil_current, 32'(100 + sp[i]));
      end
      wr(`VCHMC_OFS_CTRL, 32'h3);
      cyc(3);
      chk(coil_current, 32'h0);
      wr(`VCHMC_OFS_CTRL, 32'h17);
      wr(`VCHMC_OFS_SETPT, 32'h1);
      cyc(3);
      chk(coil_current, 32'd1100);
      wr(`VCHMC_OFS_SETPT, 32'h0);
      cyc(3);
      chk(coil_current, 32'h0);
      $display("manual test done");
   endtask
   task automatic t_supply();
      wr(`VCHMC_OFS_CTRL, 32'h7);
      wr(`VCHMC_OFS_SETPT, 32'd500);
      wr(`VCHMC_OFS_IRQ_MASK, 32'h1);
      supply(1'b1);
      chk(irq, 32'h1);
      chk(coil_current, 32'h0);
      supply(1'b0);
      rc(`VCHMC_OFS_STATUS, 32'h1);
      rc(`VCHMC_OFS_IRQ_STAT, 32'h1);
      cyc(2);
      chk(irq, 32'h0);
      wr(`VCHMC_OFS_CTRL, 32'h1);
      wr(`VCHMC_OFS_CTRL, 32'h3);
      rc(`VCHMC_OFS_STATUS, 32'h0);
      wr(`VCHMC_OFS_CTRL, 32'hb);
      supply(1'b1);
      rc(`VCHMC_OFS_STATUS, 32'h1);
      supply(1'b0);
      rc(`VCHMC_OFS_STATUS, 32'h0);
      wr(`VCHMC_OFS_CTRL, 32'h1);
      wr(`VCHMC_OFS_CTRL, 32'h0);
      wr(`VCHMC_OFS_IRQ_MASK, 32'h0);
      $display("supply test done");
   endtask
   task automatic t_defaults();
      wr(`VCHMC_OFS_CMD, 32'h1);
      rc(`VCHMC_OFS_IMIN, 32'd100);
      @(posedge clk);
      link_online <= 1'b1;
      wr(`VCHMC_OFS_CTRL, 32'h1);
      wr(`VCHMC_OFS_CTRL, 32'h3);
      wr(`VCHMC_OFS_CMD, 32'h1);
      rc(`VCHMC_OFS_IMIN, 32'd100);
      wr(`VCHMC_OFS_CTRL, 32'h1);
      rc(`VCHMC_OFS_STATUS, 32'h2);
      wr(`VCHMC_OFS_CMD, 32'h1);
      rc(`VCHMC_OFS_IMIN, {16'h0, `VCHMC_DEF_IMIN});
      rc(`VCHMC_OFS_IMAX, {16'h0, `VCHMC_DEF_IMAX});
      power();
      rc(`VCHMC_OFS_IMIN, 32'h50);
      wr(`VCHMC_OFS_CMD, 32'h1);
      wr(`VCHMC_OFS_CMD, 32'h2);
      power();
      rc(`VCHMC_OFS_IMAX, {16'h0, `VCHMC_DEF_IMAX});
      $display("defaults test done");
   endtask
   task automatic t_filter();
      // each input gets its own factor, fresh state after power-up
      for (int c = 0; c < 4; c++)
      begin
         power();
         wr(`VCHMC_OFS_FILT, 32'(((3 - c) * 2 + 1) * 16 + c * 2 + 1));
         @(posedge clk);
         ain_vld <= 2'b11;
         ain_data <= 32'h08000800;
         @(posedge clk);
         ain_vld <= 2'b00;
         cyc(3);
         rc(`VCHMC_OFS_AIN0, 32'h800 >> (3 + c));
         rc(`VCHMC_OFS_AIN1, 32'h800 >> (6 - c));
      end
      // commit the last per-input filter setting and see it back after power-up
      wr(`VCHMC_OFS_CMD, 32'h2);
      rc(`VCHMC_OFS_IRQ_STAT, 32'h4);
      power();
      rc(`VCHMC_OFS_FILT, 32'h17);
      wr(`VCHMC_OFS_FILT, 32'h0);
      @(posedge clk);
      ain_vld <= 2'b10;
      ain_data <= 32'h01230800;
      @(posedge clk);
      ain_vld <= 2'b00;
      cyc(3);
      rc(`VCHMC_OFS_AIN1, 32'h123);
      $display("filter test done");
   endtask
   // ==========================================================
   // run control
   task automatic end_of_test();
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #100000;
      num_errors++;
      end_of_test();
   end
   initial
   begin
      power();
      t_reset();
      t_modes();
      t_limits();
      t_manual();
      t_supply();
      t_defaults();
      t_filter();
      end_of_test();
   end
endmodule
`default_nettype wire
